// ==== verilog/birro_pkg.sv ====
package birro_pkg;

    // ------------------------------------------------------------
    // widths and ranges
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam logic [6:0] FADDR_MAX = 7'h7F;
    localparam int PC_W = 13;
    localparam int STACK_DEPTH = 8;

    // ------------------------------------------------------------
    // reset values and fixed targets
    // ------------------------------------------------------------
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------
    // destination select encoding
    // ------------------------------------------------------------
    localparam logic DEST_W = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // operations decoded by the core, one-hot
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        OP_OTHER               = 7'h01,
        OP_DECREMENT_FILE      = 7'h02,
        OP_INCREMENT_FILE      = 7'h04,
        OP_DECREMENT_SKIP_ZERO = 7'h08,
        OP_INCREMENT_SKIP_ZERO = 7'h10,
        OP_RETURN_FROM_IRQ     = 7'h20,
        OP_ROTATE_LEFT_CARRY   = 7'h40
    } birro_op_e;

    // ------------------------------------------------------------
    // fetch states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN    = 2'h1,
        ST_SQUASH = 2'h2
    } birro_state_e;

endpackage

// ==== verilog/birro_stack.sv ====
`timescale 1ns/1ps
module birro_stack #(
    parameter int PC_W = birro_pkg::PC_W,
    parameter int DEPTH = birro_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // push and pop
    input wire logic push,
    input wire logic pop,
    input wire logic [PC_W-1:0] push_pc,
    output logic [PC_W-1:0] stack_top
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("stack depth must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // circular storage: overflow wraps, the oldest entry is lost
    // ------------------------------------------------------------
    logic [PC_W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic [PTR_W-1:0] top_idx;

    assign ptr_d = push ? ptr_q + 1'b1 : (pop ? ptr_q - 1'b1 : ptr_q);
    assign top_idx = ptr_q - 1'b1;
    assign stack_top = mem_q[top_idx];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ptr_q <= '0;
        else
            ptr_q <= ptr_d;
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_entry
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    mem_q[i] <= '0;
                else if (push && ptr_q == PTR_W'(i))
                    mem_q[i] <= push_pc;
            end
        end
    endgenerate

endmodule

// ==== verilog/birro_core.sv ====
`timescale 1ns/1ps
module birro_core #(
    parameter int STACK_DEPTH = birro_pkg::STACK_DEPTH,
    parameter logic [12:0] IRQ_VEC = birro_pkg::IRQ_VECTOR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // instruction issue, one pulse per instruction cycle
    input wire logic instr_valid,
    input wire birro_pkg::birro_op_e instr_op,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] file_rdata,
    // interrupt entry request
    input wire logic irq_take,
    // file register write port
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    // core state
    output logic [7:0] w_q,
    output logic zero_q,
    output logic carry_q,
    output logic global_irq_enable_q,
    output logic [12:0] pc_q,
    output logic squash_q
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("return stack depth must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    birro_pkg::birro_state_e state_q;
    birro_pkg::birro_state_e state_d;
    logic squashing;
    logic irq_go;
    logic exec;
    logic is_dec;
    logic is_inc;
    logic is_decsz;
    logic is_incsz;
    logic is_reti;
    logic is_rlc;
    logic is_skip;
    logic writes_result;
    logic sets_zero;
    logic [7:0] dec_val;
    logic [7:0] inc_val;
    logic [7:0] rot_val;
    logic [7:0] result;
    logic result_zero;
    logic skip_taken;
    logic [12:0] stack_top;
    logic [12:0] pc_next_seq;
    logic addr_ok;

    assign squashing = state_q == birro_pkg::ST_SQUASH;
    // interrupt entry takes the slot only when enabled; a squashed no-op still runs first
    assign irq_go = instr_valid && irq_take && global_irq_enable_q && !squashing;
    assign addr_ok = file_addr <= birro_pkg::FADDR_MAX;
    assign exec = instr_valid && !irq_go && !squashing;
    assign is_dec = exec && instr_op == birro_pkg::OP_DECREMENT_FILE;
    assign is_inc = exec && instr_op == birro_pkg::OP_INCREMENT_FILE;
    assign is_decsz = exec && instr_op == birro_pkg::OP_DECREMENT_SKIP_ZERO;
    assign is_incsz = exec && instr_op == birro_pkg::OP_INCREMENT_SKIP_ZERO;
    assign is_reti = exec && instr_op == birro_pkg::OP_RETURN_FROM_IRQ;
    assign is_rlc = exec && instr_op == birro_pkg::OP_ROTATE_LEFT_CARRY;
    assign is_skip = is_decsz || is_incsz;
    assign sets_zero = is_dec || is_inc;
    assign writes_result = (sets_zero || is_skip || is_rlc) && addr_ok;

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    // every op reads f in the slot itself; no operand is held across slots
    assign dec_val = file_rdata - birro_pkg::ONE_BYTE;
    assign inc_val = file_rdata + birro_pkg::ONE_BYTE;
    assign rot_val = {file_rdata[6:0], carry_q};
    assign result = (is_dec || is_decsz) ? dec_val
                  : (is_inc || is_incsz) ? inc_val
                  : rot_val;
    assign result_zero = result == birro_pkg::ZERO_BYTE;
    assign skip_taken = is_skip && result_zero;
    assign pc_next_seq = pc_q + birro_pkg::PC_STEP;

    // ------------------------------------------------------------
    // fetch state: one squashed slot after a taken skip
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            birro_pkg::ST_RUN:
                if (skip_taken)
                    state_d = birro_pkg::ST_SQUASH;
            birro_pkg::ST_SQUASH:
                if (instr_valid)
                    state_d = birro_pkg::ST_RUN;
            default:
                state_d = birro_pkg::ST_RUN;
        endcase
    end

    // the squashed slot still advances pc past the discarded word
    assign squash_q = squashing;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_q <= birro_pkg::ST_RUN;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    // a pop of an empty stack wraps to the highest slot, DEPTH-1, rather than stalling
    birro_stack #(
        .PC_W(birro_pkg::PC_W),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .push(irq_go),
        .pop(is_reti),
        .push_pc(pc_q),
        .stack_top(stack_top)
    );

    // ------------------------------------------------------------
    // program counter and interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            pc_q <= birro_pkg::PC_RST;
        else if (irq_go)
            pc_q <= IRQ_VEC;
        else if (is_reti)
            pc_q <= stack_top;
        else if (instr_valid)
            pc_q <= pc_next_seq;
    end

    // entry clears the enable so the handler is not re-entered
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            global_irq_enable_q <= 1'b0;
        else if (irq_go)
            global_irq_enable_q <= 1'b0;
        else if (is_reti)
            global_irq_enable_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // flags: skip ops and return touch neither
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            zero_q <= 1'b0;
        else if (sets_zero)
            zero_q <= result_zero;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            carry_q <= 1'b0;
        else if (is_rlc)
            carry_q <= file_rdata[7];
    end

    // ------------------------------------------------------------
    // result routing by destination select
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            w_q <= birro_pkg::W_RST;
        else if (writes_result && dest_sel == birro_pkg::DEST_W)
            w_q <= result;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            file_we <= 1'b0;
            file_waddr <= '0;
            file_wdata <= birro_pkg::ZERO_BYTE;
        end
        else
        begin
            file_we <= writes_result && dest_sel == birro_pkg::DEST_FILE;
            // address and data follow every cycle; only the strobe marks a write
            file_waddr <= file_addr;
            file_wdata <= result;
        end
    end

endmodule

// ==== tb/birro_core_monitor.sv ====
`timescale 1ns/1ps
module birro_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // instruction side
    input wire logic instr_valid,
    input wire birro_pkg::birro_op_e instr_op,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [7:0] file_rdata,
    input wire logic irq_take,
    // results
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] w_q,
    input wire logic zero_q,
    input wire logic carry_q,
    input wire logic global_irq_enable_q,
    input wire logic [12:0] pc_q,
    input wire logic squash_q
);
    // ------------------------------------------------------------
    // slot decode
    // ------------------------------------------------------------
    // an interrupt entry steals the slot, so the opcode must not count then
    wire logic irq_go = instr_valid && !squash_q && irq_take && global_irq_enable_q;
    wire logic go = instr_valid && !squash_q && !irq_go;
    wire logic is_dsk = instr_op == birro_pkg::OP_DECREMENT_SKIP_ZERO;
    wire logic is_isk = instr_op == birro_pkg::OP_INCREMENT_SKIP_ZERO;
    wire logic skip_op = go && (is_dsk || is_isk);
    wire logic skip_hit = (is_dsk && file_rdata == 8'h01) || (is_isk && file_rdata == 8'hFF);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_DEC_W: assert property (go && instr_op == birro_pkg::OP_DECREMENT_FILE && !dest_sel
        |=> w_q == $past(file_rdata) - 8'h01 && zero_q == ($past(file_rdata) == 8'h01))
        else $error("decrement result wrong");
    AST_INC_F: assert property (go && instr_op == birro_pkg::OP_INCREMENT_FILE && dest_sel
        |=> file_we && file_waddr == $past(file_addr) && file_wdata == $past(file_rdata) + 8'h01)
        else $error("increment write wrong");
    AST_SKIP_FLAGS: assert property (skip_op |=> $stable(zero_q) && $stable(carry_q))
        else $error("skip changed flags");
    AST_SKIP_NZ: assert property (skip_op && !skip_hit |=> !squash_q)
        else $error("nonzero skip squashed");
    AST_SKIP_Z: assert property (skip_op && skip_hit |=> squash_q)
        else $error("zero skip not squashed");
    AST_SQUASH: assert property (squash_q && instr_valid
        |=> !squash_q && !file_we && pc_q == $past(pc_q) + 13'h0001)
        else $error("squashed slot executed");
    AST_ROT: assert property (go && instr_op == birro_pkg::OP_ROTATE_LEFT_CARRY && !dest_sel
        |=> carry_q == $past(file_rdata[7]) && w_q == {$past(file_rdata[6:0]), $past(carry_q)})
        else $error("rotate wrong");
    AST_RET: assert property (go && instr_op == birro_pkg::OP_RETURN_FROM_IRQ
        |=> global_irq_enable_q && $stable(zero_q) && $stable(carry_q))
        else $error("return wrong");
    AST_IRQ: assert property (irq_go |=> pc_q == birro_pkg::IRQ_VECTOR && $stable(w_q))
        else $error("interrupt entry wrong");
endmodule

bind birro_core birro_monitor mon (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata),
    .irq_take(irq_take), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .w_q(w_q), .zero_q(zero_q), .carry_q(carry_q), .global_irq_enable_q(global_irq_enable_q),
    .pc_q(pc_q), .squash_q(squash_q));

// ==== tb/byte_incdec_rotate_return_ops_tb_top.sv ====
`timescale 1ns/1ps
module byte_incdec_rotate_return_ops_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    birro_pkg::birro_op_e instr_op = birro_pkg::OP_OTHER;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'b0;
    logic [7:0] file_rdata = 8'h00;
    logic irq_take = 1'b0;
    logic file_we, zero_q, carry_q, global_irq_enable_q, squash_q;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata, w_q;
    logic [12:0] pc_q, p;
    int failures = 0;
    int checks = 0;

    birro_core uut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
        .file_addr(file_addr), .dest_sel(dest_sel), .file_rdata(file_rdata),
        .irq_take(irq_take), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .w_q(w_q), .zero_q(zero_q), .carry_q(carry_q),
        .global_irq_enable_q(global_irq_enable_q), .pc_q(pc_q), .squash_q(squash_q));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task summarize;
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input logic [12:0] got, input logic [12:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // slot drivers
    // ------------------------------------------------------------
    // issue returns at once so two calls give back-to-back slots
    task issue(input birro_pkg::birro_op_e op, input logic [7:0] f, input logic d, input logic i);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        file_rdata <= f;
        file_addr <= f[6:0];
        dest_sel <= d;
        irq_take <= i;
    endtask

    task done;
        @(posedge clk);
        instr_valid <= 1'b0;
        irq_take <= 1'b0;
        #1;
    endtask

    task t_incdec;
        issue(birro_pkg::OP_DECREMENT_FILE, 8'h01, 1'b0, 1'b0);
        done;
        chk(w_q, 13'h0000);
        chk(zero_q, 13'h0001);
        issue(birro_pkg::OP_DECREMENT_FILE, 8'h00, 1'b1, 1'b0);
        done;
        chk(file_wdata, 13'h00FF);
        chk(zero_q, 13'h0000);
        issue(birro_pkg::OP_INCREMENT_FILE, 8'h41, 1'b0, 1'b0);
        done;
        chk(w_q, 13'h0042);
        issue(birro_pkg::OP_INCREMENT_FILE, 8'hFF, 1'b1, 1'b0);
        done;
        chk(file_wdata, 13'h0000);
        chk(file_waddr, 13'h007F);
        chk(zero_q, 13'h0001);
    endtask

    task t_rot;
        issue(birro_pkg::OP_ROTATE_LEFT_CARRY, 8'h80, 1'b0, 1'b0);
        done;
        chk({w_q, carry_q}, 13'h0001);
        issue(birro_pkg::OP_ROTATE_LEFT_CARRY, 8'h01, 1'b1, 1'b0);
        done;
        chk({file_wdata, carry_q}, 13'h0006);
    endtask

    task t_skip;
        p = pc_q;
        issue(birro_pkg::OP_INCREMENT_SKIP_ZERO, 8'hFF, 1'b1, 1'b0);
        issue(birro_pkg::OP_INCREMENT_FILE, 8'h10, 1'b1, 1'b0);
        done;
        chk(pc_q, p + 13'h0002);
        chk(file_we, 13'h0000);
        p = pc_q;
        issue(birro_pkg::OP_DECREMENT_SKIP_ZERO, 8'h05, 1'b0, 1'b0);
        issue(birro_pkg::OP_INCREMENT_FILE, 8'h10, 1'b0, 1'b0);
        done;
        chk(w_q, 13'h0011);
        chk(pc_q, p + 13'h0002);
        p = pc_q;
        issue(birro_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01, 1'b0, 1'b0);
        issue(birro_pkg::OP_INCREMENT_FILE, 8'h10, 1'b0, 1'b0);
        done;
        chk(w_q, 13'h0000);
        chk(pc_q, p + 13'h0002);
    endtask

    task t_irq;
        issue(birro_pkg::OP_RETURN_FROM_IRQ, 8'h00, 1'b0, 1'b0);
        done;
        chk(global_irq_enable_q, 13'h0001);
        issue(birro_pkg::OP_OTHER, 8'h00, 1'b0, 1'b0);
        done;
        p = pc_q;
        issue(birro_pkg::OP_OTHER, 8'hAA, 1'b0, 1'b1);
        done;
        chk(pc_q, birro_pkg::IRQ_VECTOR);
        chk(global_irq_enable_q, 13'h0000);
        issue(birro_pkg::OP_RETURN_FROM_IRQ, 8'h00, 1'b0, 1'b0);
        done;
        chk(pc_q, p);
        chk(global_irq_enable_q, 13'h0001);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_incdec;
        t_rot;
        t_skip;
        t_irq;
        summarize;
    end

    initial
    begin
        repeat (500) @(posedge clk);
        failures++;
        summarize;
    end
endmodule
